//--- srw_defs.svh
// constants of the supply supervisor reset block: offsets, fields, timing
// assumes a 40 MHz timebase clock; included by bare name
`ifndef SRW_DEFS_SVH
`define SRW_DEFS_SVH

// ********************
// timebase
// ********************
`define SRW_CLK_HZ          40000000
`define SRW_CLK_PER_US      (`SRW_CLK_HZ / 1000000)
`define SRW_CLK_PER_MS      (`SRW_CLK_HZ / 1000)

// ********************
// timing
// ********************
// least spike width passed by the manual reset filter, rounded up
`define SRW_T_FILT_NS       100
`define SRW_FILT_CYCLES     ((`SRW_T_FILT_NS * `SRW_CLK_PER_US + 999) / 1000)
`define SRW_T_REL_MS        200
`define SRW_REL_CYCLES      (`SRW_T_REL_MS * `SRW_CLK_PER_MS)
`define SRW_T_WD_MS         1600
`define SRW_WD_CYCLES       (`SRW_T_WD_MS * `SRW_CLK_PER_MS)

// ********************
// register map
// ********************
`define SRW_ADDR_W          4
`define SRW_REG_STATUS      4'h0
`define SRW_REG_MASK        4'h4
`define SRW_REG_STATE       4'h8
`define SRW_REG_CTRL        4'hC

// status and mask bits
`define SRW_EV_W            3
`define SRW_EV_MR           0
`define SRW_EV_WD           1
`define SRW_EV_UV           2

// state register bits
`define SRW_ST_RESET        0
`define SRW_ST_ARMED        1
`define SRW_ST_MR_LVL       2
`define SRW_ST_UV_LVL       3
`define SRW_ST_KICK_LVL     4

// control: watchdog period select, reset value picks the standard period
`define SRW_SEL_W           2
`define SRW_CTRL_SEL_RST    2'h2
`define SRW_SEL_SHORTEST    2'h0
`define SRW_SEL_SHORT       2'h1
`define SRW_SEL_STANDARD    2'h2
`define SRW_SEL_LONG        2'h3

`endif

//--- srw_host_model.sv
// host controller model: receives the reset and kicks the watchdog pin
// assumes kick changes right after a rising clk edge, as a port pin would
`timescale 1ns/1ps

module srw_host_model (
    // clock
    input  wire logic        clk,
    // reset from the supervisor, active low
    input  wire logic        reset_in_n,
    // test control: enable kicking, cycles between edges
    input  wire logic        enable,
    input  wire logic [15:0] gap,
    // watchdog pin, push-pull from the host
    output logic             kick
);
    logic [15:0] cnt_q;

    // ********************
    // kick generator
    // ********************
    // idle high while held in reset; first toggle is the arming fall
    always @(posedge clk) begin
        if (reset_in_n !== 1'b1) begin
            kick  <= 1'b1;
            cnt_q <= '0;
        end else if (enable) begin
            if (cnt_q >= gap - 16'h0001) begin
                cnt_q <= '0;
                kick  <= ~kick;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule

//--- srw_pkg.sv
// types shared by the supply supervisor reset block
// assumes nothing beyond a SystemVerilog compiler
package srw_pkg;

    typedef enum logic [2:0] {
        RS_ACTIVE = 3'b001,
        RS_HOLD   = 3'b010,
        RS_RUN    = 3'b100
    } srw_rst_state_t;

    typedef enum logic [1:0] {
        WD_IDLE  = 2'b01,
        WD_ARMED = 2'b10
    } srw_wd_state_t;

endpackage

//--- srw_sync_filter.sv
// two-flop synchroniser followed by a consecutive-sample glitch filter
// assumes pin_in is asynchronous to clk
`timescale 1ns/1ps

module srw_sync_filter #(
    parameter int unsigned FILT    = 1,
    parameter logic        RST_VAL = 1'b1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // pin side
    input  wire logic pin_in,
    // filtered level
    output logic      level_q
);
    import srw_pkg::*;

    logic        s1_q;
    logic        s2_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        level_d;

    if (FILT < 1 || FILT > 65535) begin : g_bad_filt
        $error("srw_sync_filter: FILT out of range");
    end

    // the level follows only after FILT equal samples that differ from it
    always_comb begin
        cnt_d   = 16'h0000;
        level_d = level_q;
        if (s2_q != level_q) begin
            if (cnt_q == 16'(FILT - 1)) begin
                level_d = s2_q;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q    <= RST_VAL;
            s2_q    <= RST_VAL;
            cnt_q   <= 16'h0000;
            level_q <= RST_VAL;
        end else begin
            s1_q    <= pin_in;
            s2_q    <= s1_q;
            cnt_q   <= cnt_d;
            level_q <= level_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_filt_len;
        $changed(level_q) |-> $past(cnt_q) == 16'(FILT - 1);
    endproperty
    a_filt_len: assert property (p_filt_len)
        else $error("filtered level changed before filter length");

    property p_filt_follow;
        (s2_q != level_q && cnt_q == 16'(FILT - 1)) |=> level_q == $past(s2_q);
    endproperty
    a_filt_follow: assert property (p_filt_follow)
        else $error("filtered level failed to follow stable input");

endmodule

//--- srw_tb.sv
// self-checking bench of the supervisor reset block with a host model
// assumes shortened counts: release 16 cycles, watchdog 256 cycles
`timescale 1ns/1ps
`include "srw_defs.svh"

module tb;
    import srw_pkg::*;
    localparam int unsigned REL = 16;
    localparam int unsigned WD  = 256;
    logic        clk, sys_rst, manual_reset_n, supply_low, watchdog_kick_in;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, irq, reset_out, reset_out_n, reset_od_out;
    logic        reset_od_oe_n, reset_pullup_en, kick_pullup_en, host_en;
    logic [15:0] host_gap;
    int          err_count, samples_checked, seed, n, w, per, sel;

    srw_top #(.REL_CYCLES(REL), .WD_CYCLES(WD), .FILT_CYCLES(4)) dut (
        .clk(clk), .sys_rst(sys_rst), .manual_reset_n(manual_reset_n),
        .watchdog_kick_in(watchdog_kick_in), .supply_low(supply_low),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .reset_out(reset_out), .reset_out_n(reset_out_n),
        .reset_od_out(reset_od_out), .reset_od_oe_n(reset_od_oe_n),
        .reset_pullup_en(reset_pullup_en), .kick_pullup_en(kick_pullup_en));

    srw_host_model host (.clk(clk), .reset_in_n(reset_out_n),
        .enable(host_en), .gap(host_gap), .kick(watchdog_kick_in));

    // ********************
    // helpers
    // ********************
    function automatic int exp_period(input int s);
        case (s)
            0: return WD >> 8;
            1: return WD >> 4;
            2: return WD;
            default: return WD << 4;
        endcase
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        cmp(reg_rdata & m, exp, what);
    endtask

    task automatic wait_rst(input logic v, input int maxc, output int cnt);
        cnt = 0;
        while (reset_out !== v && cnt < maxc) begin
            @(negedge clk);
            cnt++;
        end
    endtask

    task automatic out_pins(input logic act);
        cmp(reset_out_n, !act, "reset_out_n");
        cmp(reset_od_oe_n, !act, "open-drain enable");
        cmp(reset_od_out, 1'b0, "open-drain data");
        cmp(reset_pullup_en, !act, "pull-up connect");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #(25 * 20000);
        err_count++;
        $display("CHECK FAILED at %0t: run hung", $time);
        conclude();
    end

    // ********************
    // scenarios
    // ********************
    initial begin
        seed = 4532;
        sys_rst = 1'b1;
        manual_reset_n = 1'b1;
        supply_low = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        host_en = 1'b0;
        host_gap = 16'h0004;
        repeat (15) @(posedge clk);
        @(negedge clk);
        cmp(reset_out, 1'b1, "reset during power-on");
        out_pins(1'b1);
        cmp(kick_pullup_en, 1'b1, "kick pull-up at power-on");
        @(posedge clk);
        sys_rst <= 1'b0;
        wait_rst(1'b0, REL + 20, n);
        cmp(n >= REL && n <= REL + 8, 1'b1, "power-up release delay");
        out_pins(1'b0);
        rd(`SRW_REG_MASK, 32'hFFFF_FFFF, 32'h0000_0000, "mask reset");
        rd(`SRW_REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0002, "ctrl reset");
        rd(4'h2, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
        wr(`SRW_REG_STATUS, 32'h0000_0007);
        $display("test startup done");

        // short manual reset pulses below the filter length
        repeat (8) begin
            w = 1 + ($unsigned($random(seed)) % 3);
            @(posedge clk);
            manual_reset_n <= 1'b0;
            repeat (w) @(posedge clk);
            manual_reset_n <= 1'b1;
            repeat (12) @(negedge clk);
            cmp(reset_out, 1'b0, "glitch ignored");
        end
        $display("test glitch done");

        // held manual reset, event status and interrupt
        @(posedge clk);
        manual_reset_n <= 1'b0;
        wait_rst(1'b1, 10, n);
        cmp(reset_out, 1'b1, "manual reset asserts");
        out_pins(1'b1);
        repeat (8 + ($unsigned($random(seed)) % 20)) @(posedge clk);
        manual_reset_n <= 1'b1;
        wait_rst(1'b0, REL + 20, n);
        cmp(n >= REL && n <= REL + 12, 1'b1, "hold after manual");
        rd(`SRW_REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0001, "manual status");
        wr(`SRW_REG_MASK, 32'h0000_0002);
        @(negedge clk);
        cmp(irq, 1'b0, "masked event");
        wr(`SRW_REG_MASK, 32'h0000_0007);
        @(negedge clk);
        cmp(irq, 1'b1, "unmasked event");
        wr(`SRW_REG_STATUS, 32'h0000_0001);
        @(negedge clk);
        cmp(irq, 1'b0, "event cleared");
        $display("test manual done");

        // undervoltage
        @(posedge clk);
        supply_low <= 1'b1;
        wait_rst(1'b1, 6, n);
        cmp(reset_out, 1'b1, "undervoltage asserts");
        out_pins(1'b1);
        repeat (3 + ($unsigned($random(seed)) % 30)) @(posedge clk);
        supply_low <= 1'b0;
        wait_rst(1'b0, REL + 20, n);
        cmp(n >= REL && n <= REL + 8, 1'b1, "hold after supply");
        rd(`SRW_REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0004, "supply status");
        wr(`SRW_REG_STATUS, 32'h0000_0004);
        $display("test supply done");

        // unarmed watchdog never times out
        repeat (600) @(negedge clk);
        cmp(reset_out, 1'b0, "unarmed stays quiet");
        cmp(kick_pullup_en, 1'b1, "unarmed pull-up");

        // armed watchdog at two period selects, then a missed kick
        for (sel = 1; sel <= 2; sel++) begin
            wr(`SRW_REG_CTRL, sel);
            per = exp_period(sel);
            w = per / 4 + ($unsigned($random(seed)) % (per / 4));
            @(posedge clk);
            host_gap <= 16'(w);
            host_en  <= 1'b1;
            repeat (per * 4) @(negedge clk);
            cmp(reset_out, 1'b0, "kicks keep reset off");
            cmp(kick_pullup_en, 1'b0, "armed pull-up off");
            rd(`SRW_REG_STATE, 32'h0000_000F, 32'h0000_0006, "armed state");
            @(posedge clk);
            host_en <= 1'b0;
            wait_rst(1'b1, per + 20, n);
            cmp(reset_out, 1'b1, "timeout asserts");
            cmp(n + w + 8 >= per, 1'b1, "timeout not early");
            wait_rst(1'b0, REL + 20, n);
            cmp(n >= REL, 1'b1, "hold after timeout");
            rd(`SRW_REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0002, "wd status");
            rd(`SRW_REG_STATE, 32'h0000_0003, 32'h0000_0000, "disarmed");
            cmp(kick_pullup_en, 1'b1, "pull-up back");
            wr(`SRW_REG_STATUS, 32'h0000_0002);
        end

        // longest period: armed once, must stay quiet past the standard one
        wr(`SRW_REG_CTRL, 32'h0000_0003);
        rd(`SRW_REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0003, "long select");
        @(posedge clk);
        host_gap <= 16'h0004;
        host_en  <= 1'b1;
        repeat (6) @(posedge clk);
        host_en  <= 1'b0;
        repeat (WD * 2) @(negedge clk);
        cmp(reset_out, 1'b0, "long period quiet");
        cmp(kick_pullup_en, 1'b0, "long period armed");
        wait_rst(1'b1, WD * 16, n);
        cmp(reset_out, 1'b1, "long period timeout");
        cmp(n + WD * 2 + 16 >= WD * 16, 1'b1, "long period length");
        $display("test watchdog done");
        conclude();
    end
endmodule

//--- srw_top.sv
// reset generator of a supply supervisor with manual reset and watchdog
// assumes one free-running 40 MHz clock and sys_rst as power-on reset;
// pins manual_reset_n, watchdog_kick_in and supply_low are asynchronous
`timescale 1ns/1ps
`include "srw_defs.svh"

// Function
// - manual reset low forces reset outputs active
// - short noise on manual reset is ignored
// - first falling kick edge arms the watchdog
// - either edge kicks and restarts the count
// - missed kick in period forces reset
// - reset active while any source asserted
// - hold reset for release delay after sources
// - rising supply waits threshold plus hysteresis, delay
// - supply below trip forces reset at once
// - supply below trip drives reset active
// - complementary outputs, active-high always push-pull
// - pull-up disconnected while low output drives
// - watchdog disarmed after any reset event
// - manual reset spikes under 100 ns filtered
// - release delay 200 ms, selectable by parameter
module srw_top #(
    parameter int unsigned REL_CYCLES  = `SRW_REL_CYCLES,
    parameter int unsigned WD_CYCLES   = `SRW_WD_CYCLES,
    parameter int unsigned FILT_CYCLES = `SRW_FILT_CYCLES
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // reset sources
    input  wire logic                   manual_reset_n,
    input  wire logic                   watchdog_kick_in,
    input  wire logic                   supply_low,
    // register port
    input  wire logic [`SRW_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    output logic                        irq,
    // reset outputs
    output logic                        reset_out,
    output logic                        reset_out_n,
    output logic                        reset_od_out,
    output logic                        reset_od_oe_n,
    output logic                        reset_pullup_en,
    output logic                        kick_pullup_en
);
    import srw_pkg::*;

    // ********************
    // parameter checks
    // ********************
    if (REL_CYCLES < 1) begin : g_bad_rel
        $error("srw_top: REL_CYCLES must be at least 1");
    end
    if (WD_CYCLES < 256 || WD_CYCLES >= 32'h1000_0000) begin : g_bad_wd
        $error("srw_top: WD_CYCLES out of range");
    end

    // ********************
    // input synchronisers
    // ********************
    localparam int NSRC = 3;
    logic [NSRC-1:0] pins;
    logic [NSRC-1:0] lvl;
    logic            mr_lvl;
    logic            kick_lvl;
    logic            uv_lvl;

    assign pins     = {supply_low, watchdog_kick_in, manual_reset_n};
    assign mr_lvl   = lvl[0];
    assign kick_lvl = lvl[1];
    assign uv_lvl   = lvl[2];

    // only the manual reset pin is glitch filtered; the supply flag must
    // act with no more delay than the synchroniser adds
    for (genvar i = 0; i < NSRC; i++) begin : g_sync
        srw_sync_filter #(
            .FILT    ((i == 0) ? FILT_CYCLES : 1),
            .RST_VAL (1'b1)
        ) u_sync (
            .clk     (clk),
            .sys_rst (sys_rst),
            .pin_in  (pins[i]),
            .level_q (lvl[i])
        );
    end

    // ********************
    // watchdog
    // ********************
    srw_wd_state_t          wd_state;
    logic                   wd_timeout;
    logic                   wd_armed;
    logic [31:0]            wd_period;
    logic [`SRW_SEL_W-1:0]  sel_q;
    logic [`SRW_SEL_W-1:0]  sel_d;
    logic                   rst_q;

    // period options step by sixteen around the standard period
    always_comb begin
        unique case (sel_q)
            `SRW_SEL_SHORTEST: wd_period = WD_CYCLES >> 8;
            `SRW_SEL_SHORT:    wd_period = WD_CYCLES >> 4;
            `SRW_SEL_STANDARD: wd_period = WD_CYCLES;
            `SRW_SEL_LONG:     wd_period = WD_CYCLES << 4;
        endcase
    end

    srw_watchdog u_wd (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .kick_lvl (kick_lvl),
        .disarm   (rst_q),
        .period   (wd_period),
        .wd_state (wd_state),
        .timeout  (wd_timeout)
    );
    assign wd_armed = (wd_state == WD_ARMED);

    // ********************
    // reset sequencer
    // ********************
    srw_rst_state_t state_q;
    srw_rst_state_t state_d;
    logic [31:0]    hold_q;
    logic [31:0]    hold_d;
    logic           por_q;
    logic           src;
    logic           rst_d;

    assign src = ~mr_lvl | uv_lvl | por_q | wd_timeout;

    always_comb begin
        state_d = state_q;
        hold_d  = 32'h0000_0000;
        unique case (state_q)
            RS_ACTIVE: begin
                if (!src) begin
                    state_d = RS_HOLD;
                end
            end
            RS_HOLD: begin
                if (src) begin
                    state_d = RS_ACTIVE;
                end else if (hold_q == REL_CYCLES - 1) begin
                    state_d = RS_RUN;
                end else begin
                    hold_d = hold_q + 32'h0000_0001;
                end
            end
            RS_RUN: begin
                if (src) begin
                    state_d = RS_ACTIVE;
                end
            end
            default: begin
                state_d = RS_ACTIVE;
            end
        endcase
    end

    assign rst_d = (state_d != RS_RUN);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q         <= RS_ACTIVE;
            hold_q          <= 32'h0000_0000;
            por_q           <= 1'b1;
            rst_q           <= 1'b1;
            reset_out_n     <= 1'b0;
            reset_od_out    <= 1'b0;
            reset_od_oe_n   <= 1'b0;
            reset_pullup_en <= 1'b0;
            kick_pullup_en  <= 1'b1;
        end else begin
            state_q         <= state_d;
            hold_q          <= hold_d;
            por_q           <= 1'b0;
            rst_q           <= rst_d;
            reset_out_n     <= ~rst_d;
            reset_od_out    <= 1'b0;
            reset_od_oe_n   <= ~rst_d;
            reset_pullup_en <= ~rst_d;
            kick_pullup_en  <= ~wd_armed;
        end
    end
    assign reset_out = rst_q;

    // ********************
    // registers and interrupt
    // ********************
    logic [`SRW_EV_W-1:0] status_q;
    logic [`SRW_EV_W-1:0] status_d;
    logic [`SRW_EV_W-1:0] mask_q;
    logic [`SRW_EV_W-1:0] mask_d;
    logic [`SRW_EV_W-1:0] events;
    logic [`SRW_EV_W-1:0] w1c;
    logic [31:0]          rdata_d;
    logic                 irq_d;
    logic                 mr_prev_q;
    logic                 uv_prev_q;

    always_comb begin
        events                = '0;
        events[`SRW_EV_MR]    = mr_prev_q & ~mr_lvl;
        events[`SRW_EV_WD]    = wd_timeout;
        events[`SRW_EV_UV]    = uv_lvl & ~uv_prev_q;
        w1c      = '0;
        mask_d   = mask_q;
        sel_d    = sel_q;
        if (reg_wr && reg_addr == `SRW_REG_STATUS) begin
            w1c = reg_wdata[`SRW_EV_W-1:0];
        end
        if (reg_wr && reg_addr == `SRW_REG_MASK) begin
            mask_d = reg_wdata[`SRW_EV_W-1:0];
        end
        if (reg_wr && reg_addr == `SRW_REG_CTRL) begin
            sel_d = reg_wdata[`SRW_SEL_W-1:0];
        end
        // an event in the clearing cycle survives the clear
        status_d = (status_q & ~w1c) | events;
        irq_d    = |(status_d & mask_d);
        rdata_d  = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `SRW_REG_STATUS: rdata_d[`SRW_EV_W-1:0] = status_q;
                `SRW_REG_MASK:   rdata_d[`SRW_EV_W-1:0] = mask_q;
                `SRW_REG_STATE: begin
                    rdata_d[`SRW_ST_RESET]    = rst_q;
                    rdata_d[`SRW_ST_ARMED]    = wd_armed;
                    rdata_d[`SRW_ST_MR_LVL]   = mr_lvl;
                    rdata_d[`SRW_ST_UV_LVL]   = uv_lvl;
                    rdata_d[`SRW_ST_KICK_LVL] = kick_lvl;
                end
                `SRW_REG_CTRL:   rdata_d[`SRW_SEL_W-1:0] = sel_q;
                default:         rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_q  <= '0;
            mask_q    <= '0;
            sel_q     <= `SRW_CTRL_SEL_RST;
            reg_rdata <= 32'h0000_0000;
            irq       <= 1'b0;
            mr_prev_q <= 1'b1;
            uv_prev_q <= 1'b1;
        end else begin
            status_q  <= status_d;
            mask_q    <= mask_d;
            sel_q     <= sel_d;
            reg_rdata <= rdata_d;
            irq       <= irq_d;
            mr_prev_q <= mr_lvl;
            uv_prev_q <= uv_lvl;
        end
    end

    // ********************
    // checks
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_mr_forces;
        !mr_lvl |=> reset_out && !reset_out_n;
    endproperty
    a_mr_forces: assert property (p_mr_forces)
        else $error("manual reset low did not force reset");

    property p_uv_forces;
        uv_lvl |=> reset_out && state_q == RS_ACTIVE;
    endproperty
    a_uv_forces: assert property (p_uv_forces)
        else $error("low supply did not force reset at once");

    property p_release_end;
        $fell(reset_out) |-> $past(state_q) == RS_HOLD
            && $past(hold_q) == REL_CYCLES - 1 && !$past(src);
    endproperty
    a_release_end: assert property (p_release_end)
        else $error("reset released before full release delay");

    property p_hold_start;
        (state_q == RS_ACTIVE && !src) |=> state_q == RS_HOLD
            && hold_q == 32'h0000_0000 && reset_out;
    endproperty
    a_hold_start: assert property (p_hold_start)
        else $error("release delay did not start from zero");

    property p_complement;
        reset_out != reset_out_n;
    endproperty
    a_complement: assert property (p_complement)
        else $error("reset outputs not complementary");

    property p_pullup_off;
        !reset_out_n |-> !reset_pullup_en && !reset_od_oe_n;
    endproperty
    a_pullup_off: assert property (p_pullup_off)
        else $error("pull-up left on while reset drives low");

    property p_wd_disarm;
        reset_out |=> !wd_armed;
    endproperty
    a_wd_disarm: assert property (p_wd_disarm)
        else $error("watchdog still armed during reset");

    property p_wd_reset;
        wd_timeout |=> reset_out ##1 reset_out;
    endproperty
    a_wd_reset: assert property (p_wd_reset)
        else $error("watchdog timeout did not force reset");

endmodule

//--- srw_watchdog.sv
// watchdog: armed by a falling kick edge, restarted by any edge
// assumes kick_lvl is already synchronised to clk
`timescale 1ns/1ps

module srw_watchdog (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // control
    input  wire logic            kick_lvl,
    input  wire logic            disarm,
    input  wire logic [31:0]     period,
    // status
    output srw_pkg::srw_wd_state_t wd_state,
    output logic                 timeout
);
    import srw_pkg::*;

    srw_wd_state_t state_q;
    srw_wd_state_t state_d;
    logic [31:0]   cnt_q;
    logic [31:0]   cnt_d;
    logic          to_d;
    logic          prev_q;
    logic          fall;
    logic          kick_edge;

    assign fall      = prev_q & ~kick_lvl;
    assign kick_edge = prev_q ^ kick_lvl;
    assign wd_state  = state_q;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        to_d    = 1'b0;
        unique case (state_q)
            WD_IDLE: begin
                cnt_d = 32'h0000_0000;
                if (!disarm && fall) begin
                    state_d = WD_ARMED;
                end
            end
            WD_ARMED: begin
                if (disarm) begin
                    state_d = WD_IDLE;
                end else if (kick_edge) begin
                    cnt_d = 32'h0000_0000;
                end else if (cnt_q >= period - 32'h0000_0001) begin
                    // the host kept no kick inside the period
                    to_d    = 1'b1;
                    state_d = WD_IDLE;
                end else begin
                    cnt_d = cnt_q + 32'h0000_0001;
                end
            end
            default: begin
                state_d = WD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= WD_IDLE;
            cnt_q   <= 32'h0000_0000;
            timeout <= 1'b0;
            prev_q  <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            timeout <= to_d;
            prev_q  <= kick_lvl;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_arm_on_fall;
        (state_q == WD_IDLE && !disarm && fall) |=> state_q == WD_ARMED;
    endproperty
    a_arm_on_fall: assert property (p_arm_on_fall)
        else $error("falling kick did not arm the watchdog");

    property p_idle_stays;
        (state_q == WD_IDLE && !fall) |=> state_q == WD_IDLE && !timeout;
    endproperty
    a_idle_stays: assert property (p_idle_stays)
        else $error("watchdog left idle without a falling kick");

    property p_kick_restart;
        (state_q == WD_ARMED && !disarm && kick_edge)
            |=> cnt_q == 32'h0000_0000 && state_q == WD_ARMED;
    endproperty
    a_kick_restart: assert property (p_kick_restart)
        else $error("kick did not restart the period count");

    property p_timeout;
        (state_q == WD_ARMED && !disarm && !kick_edge
            && cnt_q == period - 32'h0000_0001)
            |=> timeout && state_q == WD_IDLE;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("missing timeout at end of watchdog period");

endmodule
